// *** logic/pwm_channel.sv ***
`default_nettype none
module pwm_channel
    import pwm_pkg::*;
#(
    parameter int DUTY_W = 10
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic polarity,
    input wire logic [DUTY_W-1:0] dutyNext,
    input wire logic rollover,
    input wire logic [DUTY_W-1:0] timeBase,
    output logic waveOut
);
    logic [DUTY_W-1:0] dutyBuf_ff;
    logic raw_ff;
    logic nxt_raw;
    logic waveOut_ff;

    // holding copy only reaches the compare at rollover
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            dutyBuf_ff <= '0;
        else if (rollover)
            dutyBuf_ff <= dutyNext; // RL7
    end

    // duty beyond the last time base value never matches, so output stays active
    always_comb
    begin
        nxt_raw = raw_ff;
        if (!enable)
            nxt_raw = 1'b0; // RL25
        else if (rollover)
            nxt_raw = (dutyNext != '0); // RL4
        else if (timeBase == dutyBuf_ff)
            nxt_raw = 1'b0; // RL5
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            raw_ff <= 1'b0;
            waveOut_ff <= 1'b0;
        end
        else
        begin
            raw_ff <= nxt_raw; // RL6
            waveOut_ff <= nxt_raw ^ polarity; // RL19
        end
    end

    assign waveOut = waveOut_ff;
endmodule
`default_nettype wire

// *** logic/pwm_pkg.sv ***
`default_nettype none
package pwm_pkg;
    // register map, byte addresses on the bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] TCTL_OFS = 8'h00;
    localparam logic [7:0] TCNT_OFS = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam logic [7:0] TSTAT_OFS = 8'h0C;
    localparam logic [7:0] CH_BASE = 8'h10;
    localparam int CH_SHIFT = 4;
    localparam logic [1:0] CH_CON = 2'h0;
    localparam logic [1:0] CH_DCH = 2'h1;
    localparam logic [1:0] CH_DCL = 2'h2;
    localparam logic [1:0] CH_PORT = 2'h3;
    // field positions
    localparam int EN_BIT = 7;
    localparam int OE_BIT = 6;
    localparam int OUT_BIT = 5;
    localparam int POL_BIT = 4;
    localparam int DCL_HI = 7;
    localparam int DCL_LO = 6;
    localparam int PS_LO = 0;
    localparam int PS_HI = 1;
    localparam int RUN_BIT = 2;
    localparam int POST_LO = 3;
    localparam int POST_HI = 6;
    localparam int FLAG_BIT = 0;
    localparam int LATCH_BIT = 0;
    localparam int DIR_BIT = 1;
    // reset values
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [6:0] TCTL_RST = 7'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic DIR_RST = 1'b1;
    // prescaler terminal counts per select code
    localparam logic [1:0] PS_DIV1 = 2'b00;
    localparam logic [1:0] PS_DIV4 = 2'b01;
    localparam logic [1:0] PS_DIV16 = 2'b10;
    localparam logic [5:0] PS_TC1 = 6'h00;
    localparam logic [5:0] PS_TC4 = 6'h03;
    localparam logic [5:0] PS_TC16 = 6'h0F;
    localparam logic [5:0] PS_TC64 = 6'h3F;
    localparam logic [1:0] SUB_MAX = 2'h3;
    // bus
    localparam int HTRANS_ACT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_state_t;
endpackage
`default_nettype wire

// *** logic/pwm_time_base.sv ***
`default_nettype none
module pwm_time_base
    import pwm_pkg::*;
#(
    parameter int CNT_W = 8
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic runBit,
    input wire logic [1:0] prescaleSel,
    input wire logic [3:0] postscaleSel,
    input wire logic sleep,
    input wire logic cntWrite,
    input wire logic [CNT_W-1:0] cntWData,
    input wire logic preClear,
    input wire logic [CNT_W-1:0] periodLimit,
    output logic [CNT_W-1:0] count,
    output logic [CNT_W+1:0] timeBase,
    output logic rollover,
    output logic postMatch
);
    logic [CNT_W-1:0] count_ff;
    logic [1:0] sub_ff;
    logic [5:0] pre_ff;
    logic [3:0] post_ff;
    logic rollover_ff;
    logic postMatch_ff;
    logic advance;
    logic tick;
    logic wrap;
    logic hit;

    function automatic logic [5:0] preLimit(input logic [1:0] sel);
        case (sel)
            PS_DIV1: preLimit = PS_TC1;
            PS_DIV4: preLimit = PS_TC4;
            PS_DIV16: preLimit = PS_TC16;
            default: preLimit = PS_TC64;
        endcase
    endfunction

    // sleep freezes prescaler, sub-count and timer in place; bus writes to count and control still take effect
    assign advance = runBit & ~sleep; // RL14
    assign tick = advance && (pre_ff == preLimit(prescaleSel)); // RL23
    assign wrap = tick && (sub_ff == SUB_MAX); // RL12
    assign hit = wrap && (count_ff == periodLimit); // RL10

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_ff <= '0;
            sub_ff <= '0;
        end
        else
        begin
            if (cntWrite || preClear)
                pre_ff <= '0;
            else if (advance)
                pre_ff <= tick ? 6'h00 : 6'(pre_ff + 6'h01);
            if (cntWrite)
                sub_ff <= '0;
            else if (tick)
                sub_ff <= 2'(sub_ff + 2'h1); // RL12
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_ff <= '0;
            rollover_ff <= 1'b0;
        end
        else
        begin
            if (cntWrite)
                count_ff <= cntWData;
            else if (hit)
                count_ff <= '0; // RL9
            else if (wrap)
                count_ff <= CNT_W'(count_ff + 1'b1);
            rollover_ff <= hit; // RL9
        end
    end

    // postscaler only feeds the match flag and timerMatch, never the waveform
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            post_ff <= '0;
            postMatch_ff <= 1'b0;
        end
        else
        begin
            postMatch_ff <= 1'b0;
            if (cntWrite || preClear)
                post_ff <= '0;
            else if (hit)
            begin
                if (post_ff == postscaleSel)
                begin
                    post_ff <= '0;
                    postMatch_ff <= 1'b1; // RL3
                end
                else
                    post_ff <= 4'(post_ff + 4'h1);
            end
        end
    end

    assign count = count_ff;
    assign timeBase = {count_ff, sub_ff}; // RL12
    assign rollover = rollover_ff;
    assign postMatch = postMatch_ff;
endmodule
`default_nettype wire

// *** logic/pwm_top.sv ***
// Function
// RL1 - each channel makes a PWM waveform with 10-bit duty resolution
// RL2 - one shared period from timer and period register, per-channel duty values
// RL3 - timer postscaler never affects the waveform
// RL4 - outputs go active when the timer count clears to zero
// RL5 - output clears when 10-bit time base equals buffered duty
// RL6 - duty at or above the period keeps the output active all cycle
// RL7 - duty writes allowed anytime, reach compare only at rollover
// RL8 - software writes both duty registers before the next period match
// RL9 - after period match: clear timer, set outputs unless zero duty, latch duty
// RL10 - period is (period+1) times four clocks times prescale
// RL11 - duty high byte is bits 9:2, low register bits 7:6 are bits 1:0
// RL12 - time base is timer count plus two sub-count bits, scaled by prescaler
// RL13 - full resolution only with period 255, fewer steps below
// RL14 - sleep freezes timer and channels, pins hold, count resumes after
// RL15 - reset puts pins to input and registers to reset values
// RL16 - control bit 7 enables the channel
// RL17 - control bit 6 routes waveform to pin, clear gives pin to port latch
// RL18 - control bit 5 is read-only present output value, resets zero
// RL19 - control bit 4 set makes the output active-low
// RL20 - control bits 3:0 read zero and ignore writes
// RL21 - software clears the port direction bit to make the pin an output
// RL22 - software follows the fixed setup order for a complete first period
// RL23 - prescale codes 00,01,10,11 divide by 1,4,16,64
// RL24 - duty low register holds bits 7:6, bits 5:0 read zero
// RL25 - disabled channel holds inactive level and ignores compares
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`default_nettype none
module pwm_top
    import pwm_pkg::*;
#(
    parameter int NCH = 4
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sleep,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [NCH-1:0] pinOut,
    output logic [NCH-1:0] pinOe_n,
    output logic [NCH-1:0] waveOut,
    output logic timerMatch
);
    localparam logic [7:0] MAP_END = 8'(CH_BASE + 8'(NCH << CH_SHIFT));

    bus_state_t state_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic mapped_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic accept;
    logic wrCommit;
    logic [31:0] rdMux;

    logic [6:0] tctl_ff;
    logic [7:0] period_ff;
    logic flag_ff;
    logic timerMatch_ff;
    logic [NCH-1:0] en_ff;
    logic [NCH-1:0] oe_ff;
    logic [NCH-1:0] pol_ff;
    logic [7:0] dch_ff [NCH];
    logic [1:0] dcl_ff [NCH];
    logic [NCH-1:0] latch_ff;
    logic [NCH-1:0] dir_ff;
    logic [NCH-1:0] pinOut_ff;
    logic [NCH-1:0] pinOe_n_ff;

    logic [7:0] count;
    logic [9:0] timeBase;
    logic rollover;
    logic postMatch;
    logic [NCH-1:0] wave;

    function automatic logic isMapped(input logic [31:0] a);
        isMapped = (a[31:ADDR_W] == '0) && (a[ADDR_W-1:0] < MAP_END) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic isChan(input logic [ADDR_W-1:0] a);
        isChan = (a >= CH_BASE) && (a < MAP_END);
    endfunction

    function automatic int chIdx(input logic [ADDR_W-1:0] a);
        chIdx = int'((a - CH_BASE) >> CH_SHIFT);
    endfunction

    function automatic logic [1:0] chReg(input logic [ADDR_W-1:0] a);
        chReg = a[3:2];
    endfunction

    // --- AHB-Lite slave: writes complete with no wait, reads take one wait state
    assign accept = hsel && htrans[HTRANS_ACT] && hready;
    assign wrCommit = (state_ff == BUS_WRITE) && mapped_ff;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= BUS_IDLE;
            addr_ff <= '0;
            mapped_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= '0;
        end
        else
        begin
            case (state_ff)
                BUS_IDLE, BUS_WRITE:
                begin
                    if (accept)
                    begin
                        addr_ff <= haddr[ADDR_W-1:0];
                        mapped_ff <= isMapped(haddr);
                        if (hwrite)
                        begin
                            // only whole-word writes change registers
                            mapped_ff <= isMapped(haddr) && (hsize == HSIZE_WORD);
                            state_ff <= BUS_WRITE;
                        end
                        else
                        begin
                            // wait one cycle so a write committing now is seen
                            state_ff <= BUS_READ;
                            hreadyout_ff <= 1'b0;
                        end
                    end
                    else
                        state_ff <= BUS_IDLE;
                end
                BUS_READ:
                begin
                    hrdata_ff <= mapped_ff ? rdMux : 32'h0000_0000;
                    hreadyout_ff <= 1'b1;
                    state_ff <= BUS_IDLE;
                end
                default:
                begin
                    state_ff <= BUS_IDLE;
                    hreadyout_ff <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        rdMux = '0;
        if (isChan(addr_ff))
        begin
            case (chReg(addr_ff))
                CH_CON:
                begin
                    rdMux[EN_BIT] = en_ff[chIdx(addr_ff)];
                    rdMux[OE_BIT] = oe_ff[chIdx(addr_ff)];
                    rdMux[OUT_BIT] = wave[chIdx(addr_ff)]; // RL18
                    rdMux[POL_BIT] = pol_ff[chIdx(addr_ff)]; // RL19
                end
                CH_DCH: rdMux[7:0] = dch_ff[chIdx(addr_ff)];
                CH_DCL: rdMux[DCL_HI:DCL_LO] = dcl_ff[chIdx(addr_ff)]; // RL24
                default:
                begin
                    rdMux[LATCH_BIT] = latch_ff[chIdx(addr_ff)];
                    rdMux[DIR_BIT] = dir_ff[chIdx(addr_ff)];
                end
            endcase
        end
        else
        begin
            case (addr_ff)
                TCTL_OFS: rdMux[6:0] = tctl_ff;
                TCNT_OFS: rdMux[7:0] = count;
                PERIOD_OFS: rdMux[7:0] = period_ff;
                TSTAT_OFS: rdMux[FLAG_BIT] = flag_ff;
                default: rdMux = '0;
            endcase
        end
    end

    // --- shared timer registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tctl_ff <= TCTL_RST;
            period_ff <= PERIOD_RST; // RL15
        end
        else if (wrCommit)
        begin
            if (addr_ff == TCTL_OFS)
                tctl_ff <= hwdata[6:0];
            if (addr_ff == PERIOD_OFS)
                period_ff <= hwdata[7:0]; // RL13
        end
    end

    // match flag: a new match in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_ff <= 1'b0;
            timerMatch_ff <= 1'b0;
        end
        else
        begin
            if (postMatch)
                flag_ff <= 1'b1;
            else if (wrCommit && (addr_ff == TSTAT_OFS) && hwdata[FLAG_BIT])
                flag_ff <= 1'b0;
            timerMatch_ff <= postMatch;
        end
    end

    // --- per-channel registers; duty writes land in the holding copy only
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_ff <= '0;
            oe_ff <= '0;
            pol_ff <= '0;
            latch_ff <= '0;
            dir_ff <= {NCH{DIR_RST}}; // RL15
            for (int i = 0; i < NCH; i++)
            begin
                dch_ff[i] <= DUTY_RST;
                dcl_ff[i] <= DUTY_RST[1:0];
            end
        end
        else if (wrCommit && isChan(addr_ff))
        begin
            case (chReg(addr_ff))
                CH_CON:
                begin
                    en_ff[chIdx(addr_ff)] <= hwdata[EN_BIT]; // RL16
                    oe_ff[chIdx(addr_ff)] <= hwdata[OE_BIT]; // RL17
                    pol_ff[chIdx(addr_ff)] <= hwdata[POL_BIT]; // RL19
                end
                CH_DCH: dch_ff[chIdx(addr_ff)] <= hwdata[7:0]; // RL7
                CH_DCL: dcl_ff[chIdx(addr_ff)] <= hwdata[DCL_HI:DCL_LO]; // RL7
                default:
                begin
                    latch_ff[chIdx(addr_ff)] <= hwdata[LATCH_BIT];
                    dir_ff[chIdx(addr_ff)] <= hwdata[DIR_BIT];
                end
            endcase
        end
    end

    pwm_time_base #(
        .CNT_W(8)
    ) u_time_base (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .runBit(tctl_ff[RUN_BIT]),
        .prescaleSel(tctl_ff[PS_HI:PS_LO]),
        .postscaleSel(tctl_ff[POST_HI:POST_LO]),
        .sleep(sleep),
        .cntWrite(wrCommit && (addr_ff == TCNT_OFS)),
        .cntWData(hwdata[7:0]),
        .preClear(wrCommit && (addr_ff == TCTL_OFS)),
        .periodLimit(period_ff),
        .count(count),
        .timeBase(timeBase),
        .rollover(rollover),
        .postMatch(postMatch)
    );

    // every channel shares the one time base and rollover
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        pwm_channel #(
            .DUTY_W(10)
        ) u_channel (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .enable(en_ff[g]),
            .polarity(pol_ff[g]),
            .dutyNext({dch_ff[g], dcl_ff[g]}), // RL11
            .rollover(rollover), // RL2
            .timeBase(timeBase),
            .waveOut(wave[g]) // RL1
        );
    end

    // pin mux: waveform or port latch; output enable follows the direction bit
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinOut_ff <= '0;
            pinOe_n_ff <= '1; // RL15
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                pinOut_ff[i] <= oe_ff[i] ? wave[i] : latch_ff[i]; // RL17
                pinOe_n_ff[i] <= dir_ff[i]; // RL21
            end
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = 1'b0;
    assign pinOut = pinOut_ff;
    assign pinOe_n = pinOe_n_ff;
    assign waveOut = wave;
    assign timerMatch = timerMatch_ff;
endmodule
`default_nettype wire

// *** verification/pwm_load.sv ***
`default_nettype none
module pwm_load(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic waveIn,
    input wire logic pinLevel,
    input wire logic pinOe_n,
    output logic padLevel,
    output logic [15:0] highLen,
    output logic [15:0] perLen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;
    logic [15:0] hCnt;
    logic [15:0] pCnt;
    // released pin falls to the pull-down, never keeps the last level
    assign padLevel = pinOe_n ? 1'b0 : pinLevel;
    // lengths of the last whole period, rising edge to rising edge
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev <= 1'b0;
            hCnt <= '0;
            pCnt <= '0;
            highLen <= '0;
            perLen <= '0;
        end
        else
        begin
            prev <= waveIn;
            if (waveIn && !prev)
            begin
                perLen <= pCnt;
                highLen <= hCnt;
                pCnt <= 16'h1;
                hCnt <= 16'h1;
            end
            else
            begin
                pCnt <= pCnt + 16'h1;
                hCnt <= hCnt + 16'(waveIn);
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/pwm_top_assertions.sv ***
`default_nettype none
module pwm_checker
    import pwm_pkg::*;
#(
    parameter int NCH = 4
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sleep,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [NCH-1:0] pinOut,
    input wire logic [NCH-1:0] pinOe_n,
    input wire logic [NCH-1:0] waveOut,
    input wire logic timerMatch
);
    logic acc;
    logic wrPh_ff;
    logic [1:0] up_ff;
    assign acc = hsel && htrans[1] && hready;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wrPh_ff <= 1'b0;
        else
            wrPh_ff <= acc && hwrite;
    end
    // settle count keeps $stable away from values seen before a reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            up_ff <= 2'h0;
        else if (up_ff != 2'h3)
            up_ff <= up_ff + 2'h1;
    end
    property p_wr_zero_wait;
        acc && hwrite |=> hreadyout;
    endproperty
    a_wr_zero_wait: assert property (p_wr_zero_wait) else $error("write data phase stalled");
    property p_rd_one_wait;
        acc && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_one_wait: assert property (p_rd_one_wait) else $error("read wait state wrong");
    property p_rdata_stands;
        up_ff == 2'h3 && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_reset_pins;
        $rose(arst_n) |-> pinOe_n == {NCH{1'b1}} && pinOut == '0 && waveOut == '0 && hrdata == '0;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("outputs not at reset level");
    property p_sleep_freeze;
        up_ff == 2'h3 && sleep ##1 sleep ##1 sleep |=> $stable(waveOut) && $stable(pinOut);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("output moved while asleep");
    property p_match_pulse;
        timerMatch |=> !timerMatch;
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
    property p_dir_hold;
        up_ff == 2'h3 && !wrPh_ff && !$past(wrPh_ff) |=> $stable(pinOe_n);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("pin direction moved without write");
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb;
    import pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 4;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sleep = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic hready;
    logic hreadyout, hresp, timerMatch;
    logic [31:0] hrdata, q;
    logic [NCH-1:0] pinOut, pinOe_n, waveOut, padLevel;
    logic [15:0] highLen [NCH];
    logic [15:0] perLen [NCH];
    int n_fail = 0;
    int compares = 0;
    int n;
    logic [9:0] dutyT [NCH] = '{10'd5, 10'd16, 10'd0, 10'd5};
    logic [7:0] ctlT [NCH] = '{8'h80, 8'h80, 8'h80, 8'h90};
    assign hready = hreadyout;
    always #50 ref_clk = ~ref_clk;
    pwm_top #(.NCH(NCH)) i_dut(.ref_clk, .arst_n, .sleep, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pinOut, .pinOe_n, .waveOut, .timerMatch);
    for (genvar g = 0; g < NCH; g++)
    begin : g_load
        pwm_load i_load(.ref_clk(ref_clk), .arst_n(arst_n), .waveIn(waveOut[g]), .pinLevel(pinOut[g]),
            .pinOe_n(pinOe_n[g]), .padLevel(padLevel[g]), .highLen(highLen[g]), .perLen(perLen[g]));
    end
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b1, d);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        acc(a, 1'b0, 8'h00);
        chk(nm, q, exp);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic padCount(output int c);
        c = 0;
        // pin register lags the register write by one clock
        @(posedge ref_clk);
        repeat (8)
        begin
            @(posedge ref_clk);
            c += int'(padLevel[0]);
        end
    endtask
    function automatic logic [7:0] ca(input int ch, input logic [1:0] r);
        return CH_BASE + 8'(ch * 16) + {4'h0, r, 2'b00};
    endfunction
    initial
    begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rc("period", PERIOD_OFS, 32'hFF);
        rc("tctl", TCTL_OFS, 32'h0);
        rc("ctl", ca(0, CH_CON), 32'h0);
        rc("port", ca(0, CH_PORT), 32'h2);
        rc("unmapped", 8'hF0, 32'h0);
        chk("oe", 32'(pinOe_n), 32'hF);
        wr(ca(1, CH_CON), 8'h2F);
        rc("ctl ro", ca(1, CH_CON), 32'h0);
        wr(ca(1, CH_DCL), 8'hFF);
        rc("dcl", ca(1, CH_DCL), 32'hC0);
        wr(ca(1, CH_DCH), 8'hA5);
        rc("dch", ca(1, CH_DCH), 32'hA5);
        // setup in the order that yields a whole first period
        wr(PERIOD_OFS, 8'h03);
        for (int c = 0; c < NCH; c++)
        begin
            wr(ca(c, CH_CON), 8'h00);
            wr(ca(c, CH_DCH), dutyT[c][9:2]);
            wr(ca(c, CH_DCL), {dutyT[c][1:0], 6'h00});
        end
        wr(TSTAT_OFS, 8'h01);
        wr(TCTL_OFS, 8'h1C);
        // q still holds the last read word, so clear it before polling
        q = '0;
        for (int i = 0; i < 40 && q[0] !== 1'b1; i++)
            acc(TSTAT_OFS, 1'b0, 8'h00);
        if (q[0] !== 1'b1)
        begin
            n_fail++;
            wrap_up();
        end
        for (int c = 0; c < NCH; c++)
            wr(ca(c, CH_CON), ctlT[c]);
        cyc(60);
        for (int c = 0; c < NCH; c++)
        begin
            if (dutyT[c] % 16 != 0)
            begin
                chk("per", 32'(perLen[c]), 32'd16);
                chk("high", 32'(highLen[c]), ctlT[c][4] ? 32'(16 - dutyT[c]) : 32'(dutyT[c]));
            end
            else
            begin
                chk("no rise", 32'(highLen[c]), 32'd0);
                chk("level", 32'(waveOut[c]), 32'(dutyT[c] != 0));
            end
        end
        for (int k = 0; k < 2; k++)
        begin
            for (n = 1; n < 200 && timerMatch !== 1'b1; n++)
                @(posedge ref_clk);
            @(posedge ref_clk);
        end
        chk("match spacing", 32'(n), 32'd64);
        sleep <= 1'b1;
        cyc(30);
        sleep <= 1'b0;
        cyc(40);
        chk("resume", 32'(perLen[0]), 32'd16);
        wr(PERIOD_OFS, 8'h00);
        // a count already above the new limit would run on to the top first
        wr(TCNT_OFS, 8'h00);
        wr(ca(0, CH_DCH), 8'h00);
        wr(ca(0, CH_DCL), 8'h40);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(TCTL_OFS, 8'(4 + ps));
            cyc(12 * (1 << (2 * ps)) + 20);
            chk("ps per", 32'(perLen[0]), 32'(4 << (2 * ps)));
            chk("ps high", 32'(highLen[0]), 32'(1 << (2 * ps)));
        end
        rc("out bit", ca(1, CH_CON), 32'hA0);
        wr(ca(0, CH_CON), 8'h10);
        cyc(10);
        chk("off inv", 32'(waveOut[0]), 32'h1);
        wr(TCTL_OFS, 8'h04);
        wr(ca(0, CH_PORT), 8'h00);
        wr(ca(0, CH_CON), 8'hC0);
        cyc(20);
        padCount(n);
        chk("pin wave", 32'(n), 32'd2);
        wr(ca(0, CH_CON), 8'h80);
        wr(ca(0, CH_PORT), 8'h01);
        padCount(n);
        chk("pin latch", 32'(n), 32'd8);
        wr(ca(0, CH_PORT), 8'h03);
        padCount(n);
        chk("pin input", 32'(n), 32'd0);
        wrap_up();
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end
endmodule
bind pwm_top pwm_checker #(.NCH(NCH)) i_chk(.ref_clk, .arst_n, .sleep, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pinOut, .pinOe_n, .waveOut, .timerMatch);
`default_nettype wire
